// ---- hdl/pcsr_pkg.sv ----
// Constants, register indices and field layout of the copper status and control registers
package pcsr_pkg;

  // Register data width as seen by management software
  localparam int unsigned REG_W = 16;

  // Register indices; byte address on APB is four times the index
  localparam logic [5:0] INT_EN_IDX = 6'h12;
  localparam logic [5:0] EVT_STAT_IDX = 6'h13;
  localparam logic [5:0] TX_POL_IDX = 6'h14;
  localparam logic [5:0] RX_ERR_IDX = 6'h15;
  localparam logic [5:0] PAGE_SEL_IDX = 6'h16;
  localparam logic [5:0] OEM_CTRL_IDX = 6'h19;
  localparam logic [5:0] SW_RESET_IDX = 6'h1f;

  // Event bit positions in the event status register
  localparam int unsigned EVT_ANEG_ERR_BIT = 15;
  localparam int unsigned EVT_SPEED_BIT = 14;
  localparam int unsigned EVT_DUPLEX_BIT = 13;
  localparam int unsigned EVT_PAGE_BIT = 12;
  localparam int unsigned EVT_ANEG_DONE_BIT = 11;
  localparam int unsigned EVT_LINK_BIT = 10;
  localparam int unsigned EVT_SYMBOL_BIT = 9;
  localparam int unsigned EVT_FALSE_CARRIER_BIT = 8;
  localparam int unsigned EVT_CROSSOVER_BIT = 6;
  localparam int unsigned EVT_DOWNSHIFT_BIT = 5;
  localparam int unsigned EVT_ENERGY_BIT = 4;
  localparam int unsigned EVT_FLP_NO_LINK_BIT = 3;
  localparam int unsigned EVT_POLARITY_BIT = 1;
  localparam int unsigned EVT_JABBER_BIT = 0;

  // Bits 7 and 2 are reserved and always read zero
  localparam logic [15:0] EVT_VALID_MASK = 16'hff7b;

  // OEM control field positions
  localparam int unsigned OEM_RESTART_BIT = 10;
  localparam int unsigned OEM_GIG_DIS_BIT = 6;
  localparam int unsigned OEM_LOW_POWER_BIT = 2;
  // Fields that survive a software reset
  localparam logic [15:0] OEM_RETAIN_MASK = 16'h0044;

  // Field masks of the narrow registers
  localparam logic [15:0] TX_POL_MASK = 16'h000f;
  localparam logic [15:0] PAGE_SEL_MASK = 16'h00ff;
  localparam int unsigned SW_RESET_BIT = 0;

  // Values after hardware reset
  localparam logic [15:0] EVT_RESET = 16'h0000;
  localparam logic [15:0] TX_POL_RESET = 16'h0000;
  localparam logic [15:0] RX_ERR_RESET = 16'h0000;
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [15:0] OEM_RESET = 16'h0000;
  localparam logic [15:0] INT_EN_RESET = 16'h0000;

endpackage : pcsr_pkg

// ---- hdl/pcsr_err_counter.sv ----
// Saturating receive error counter with read-clear that keeps concurrent counts
module pcsr_err_counter
  import pcsr_pkg::*;
#(
  parameter int unsigned CNT_W = 16
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Error events, one-cycle pulses
  input wire logic symbol_err,
  input wire logic false_carrier,
  // Read clear, subtracts the value software saw
  input wire logic clr_en,
  input wire logic [CNT_W-1:0] clr_val,
  // Current count
  output logic [CNT_W-1:0] count
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } pcsr_cnt_state_t;

  pcsr_cnt_state_t st_ff;
  pcsr_cnt_state_t nxt_st;

  // Next count: remove what was read, then add the new errors
  always_comb
  begin
    logic [CNT_W-1:0] base;
    logic [CNT_W:0] sum;
    base = '0;
    sum = '0;
    nxt_st = st_ff;
    if (clr_en)
    begin
      base = st_ff.cnt - clr_val;
    end
    else
    begin
      base = st_ff.cnt;
    end
    sum = {1'b0, base} + {{CNT_W{1'b0}}, symbol_err} + {{CNT_W{1'b0}}, false_carrier};
    if (sum[CNT_W])
    begin
      nxt_st.cnt = {CNT_W{1'b1}};
    end
    else
    begin
      nxt_st.cnt = sum[CNT_W-1:0];
    end
  end

  // State register; software reset does not reach it, so the count is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.cnt <= RX_ERR_RESET[CNT_W-1:0];
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.cnt;

endmodule // pcsr_err_counter

// ---- hdl/pcsr_event_latch.sv ----
// Change detection and latched-high event bits of the copper event status register
module pcsr_event_latch
  import pcsr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_reset,
  // Auto-negotiation fault pulses
  input wire logic ms_unresolved,
  input wire logic parallel_detect_fault,
  input wire logic no_highest_common_capability,
  input wire logic link_fail_after_aneg,
  // Other event pulses
  input wire logic page_received,
  input wire logic aneg_complete,
  input wire logic symbol_err,
  input wire logic false_carrier,
  input wire logic downshift,
  input wire logic fast_link_pulse_no_link,
  input wire logic jabber,
  // Real-time levels watched for change
  input wire logic [1:0] speed,
  input wire logic full_duplex,
  input wire logic link_up,
  input wire logic mdix,
  input wire logic energy_sleep,
  input wire logic rx_pol_reversed,
  // Read clear with the snapshot software saw
  input wire logic clr_en,
  input wire logic [15:0] clr_mask,
  // Latched events
  output logic [15:0] events
);

  typedef struct packed {
    logic primed;
    logic [1:0] speed;
    logic duplex;
    logic link;
    logic mdix;
    logic energy;
    logic pol;
    logic [15:0] evt;
  } pcsr_evt_state_t;

  pcsr_evt_state_t st_ff;
  pcsr_evt_state_t nxt_st;

  // Set terms, then clear, with set winning
  always_comb
  begin
    logic [15:0] set;
    logic chk;
    set = '0;
    nxt_st = st_ff;
    // Levels are compared only once a first sample is held, else reset looks like a change
    chk = st_ff.primed;
    set[EVT_ANEG_ERR_BIT] = ms_unresolved | parallel_detect_fault
                          | no_highest_common_capability | link_fail_after_aneg;
    set[EVT_SPEED_BIT] = chk & (speed != st_ff.speed);
    set[EVT_DUPLEX_BIT] = chk & (full_duplex != st_ff.duplex);
    set[EVT_PAGE_BIT] = page_received;
    set[EVT_ANEG_DONE_BIT] = aneg_complete;
    set[EVT_LINK_BIT] = chk & (link_up != st_ff.link);
    set[EVT_SYMBOL_BIT] = symbol_err;
    set[EVT_FALSE_CARRIER_BIT] = false_carrier;
    set[EVT_CROSSOVER_BIT] = chk & (mdix != st_ff.mdix);
    set[EVT_DOWNSHIFT_BIT] = downshift;
    set[EVT_ENERGY_BIT] = chk & (energy_sleep != st_ff.energy);
    set[EVT_FLP_NO_LINK_BIT] = fast_link_pulse_no_link;
    set[EVT_POLARITY_BIT] = chk & (rx_pol_reversed != st_ff.pol);
    set[EVT_JABBER_BIT] = jabber;
    // Track the levels every cycle
    nxt_st.primed = 1'b1;
    nxt_st.speed = speed;
    nxt_st.duplex = full_duplex;
    nxt_st.link = link_up;
    nxt_st.mdix = mdix;
    nxt_st.energy = energy_sleep;
    nxt_st.pol = rx_pol_reversed;
    if (soft_reset)
    begin
      nxt_st.evt = EVT_RESET;
    end
    else if (clr_en)
    begin
      nxt_st.evt = ((st_ff.evt & ~clr_mask) | set) & EVT_VALID_MASK;
    end
    else
    begin
      nxt_st.evt = (st_ff.evt | set) & EVT_VALID_MASK;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign events = st_ff.evt;

endmodule // pcsr_event_latch

// ---- hdl/pcsr_regs.sv ----
// APB register bank of the copper status and control registers
//
// Chosen here: the APB interface to the registers.
module pcsr_regs
  import pcsr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned CNT_W = 16
)
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Negotiation fault pulses from the copper core
  input wire logic ms_unresolved,
  input wire logic parallel_detect_fault,
  input wire logic no_highest_common_capability,
  input wire logic link_fail_after_aneg,
  // Event pulses from the copper core
  input wire logic page_received,
  input wire logic aneg_complete,
  input wire logic symbol_err,
  input wire logic false_carrier,
  input wire logic downshift,
  input wire logic fast_link_pulse_no_link,
  input wire logic jabber,
  // Real-time status levels from the copper core
  input wire logic [1:0] speed,
  input wire logic full_duplex,
  input wire logic link_up,
  input wire logic mdix,
  input wire logic energy_sleep,
  input wire logic rx_pol_reversed,
  // Controls toward the copper core
  output logic [3:0] tx_pair_invert,
  output logic aneg_restart,
  output logic gigabit_disable,
  output logic low_power_link_select,
  output logic [7:0] page_sel,
  output logic soft_reset,
  // PHY interrupt, level
  output logic phy_int
);

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [3:0] txpol;
    logic [15:0] oem;
    logic [7:0] page;
    logic [15:0] int_en;
    logic irq;
    logic [15:0] snap_evt;
    logic [CNT_W-1:0] snap_cnt;
    logic swrst;
  } pcsr_regs_state_t;

  pcsr_regs_state_t st_ff;
  pcsr_regs_state_t nxt_st;

  // Latched events and error count from the submodules
  logic [15:0] evt_q;
  logic [CNT_W-1:0] cnt_q;
  // Read-clear strobes, valid at the completing edge of a read
  logic evt_clr;
  logic cnt_clr;
  // Decode of the held address
  logic [5:0] idx;
  logic hit;
  logic access;

  // Word index when the address is aligned and in range, else out of map
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] word;
    word = a >> 2;
    if (a[1:0] != 2'b00 || word > ADDR_W'(6'h3f))
    begin
      reg_index = 6'h00;
    end
    else
    begin
      reg_index = word[5:0];
    end
  endfunction

  // Is the index mapped; page 0 registers only answer while page 0 is selected
  function automatic logic reg_mapped(input logic [5:0] i, input logic [7:0] pg,
                                      input logic [ADDR_W-1:0] a);
    logic pg0;
    pg0 = (pg == 8'h00);
    if (a[1:0] != 2'b00 || (a >> 2) > ADDR_W'(6'h3f))
    begin
      reg_mapped = 1'b0;
    end
    else
    begin
      unique case (i)
        INT_EN_IDX, EVT_STAT_IDX, TX_POL_IDX, RX_ERR_IDX, OEM_CTRL_IDX: reg_mapped = pg0;
        PAGE_SEL_IDX, SW_RESET_IDX: reg_mapped = 1'b1;
        default: reg_mapped = 1'b0;
      endcase
    end
  endfunction

  // Byte-lane merge of a 16-bit register with the write data
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    lane_merge = old;
    if (strb[0])
    begin
      lane_merge[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      lane_merge[15:8] = wd[15:8];
    end
  endfunction

  assign idx = reg_index(paddr);
  assign hit = reg_mapped(idx, st_ff.page, paddr);
  // Access edge: the master holds the request until it sees pready
  assign access = psel & penable & st_ff.ready;
  assign evt_clr = access & ~pwrite & ~st_ff.err & (idx == EVT_STAT_IDX);
  assign cnt_clr = access & ~pwrite & ~st_ff.err & (idx == RX_ERR_IDX);

  // Latched-high event bits
  pcsr_event_latch u_events (
    .pclk(pclk),
    .presetn(presetn),
    .soft_reset(st_ff.swrst),
    .ms_unresolved(ms_unresolved),
    .parallel_detect_fault(parallel_detect_fault),
    .no_highest_common_capability(no_highest_common_capability),
    .link_fail_after_aneg(link_fail_after_aneg),
    .page_received(page_received),
    .aneg_complete(aneg_complete),
    .symbol_err(symbol_err),
    .false_carrier(false_carrier),
    .downshift(downshift),
    .fast_link_pulse_no_link(fast_link_pulse_no_link),
    .jabber(jabber),
    .speed(speed),
    .full_duplex(full_duplex),
    .link_up(link_up),
    .mdix(mdix),
    .energy_sleep(energy_sleep),
    .rx_pol_reversed(rx_pol_reversed),
    .clr_en(evt_clr),
    .clr_mask(st_ff.snap_evt),
    .events(evt_q)
  );

  // Receive error counter
  pcsr_err_counter #(
    .CNT_W(CNT_W)
  ) u_errcnt (
    .pclk(pclk),
    .presetn(presetn),
    .symbol_err(symbol_err),
    .false_carrier(false_carrier),
    .clr_en(cnt_clr),
    .clr_val(st_ff.snap_cnt),
    .count(cnt_q)
  );

  // Bus answer, register writes, software reset and interrupt
  always_comb
  begin
    logic [15:0] wv;
    logic [15:0] rd;
    wv = '0;
    rd = '0;
    nxt_st = st_ff;
    // Software reset lasts one cycle
    nxt_st.swrst = 1'b0;
    nxt_st.oem[OEM_RESTART_BIT] = 1'b0;
    // Answer one cycle after setup; pready only during the access phase
    nxt_st.ready = 1'b0;
    if (psel && !penable)
    begin
      // Setup: capture read data now so prdata comes from a flop
      nxt_st.ready = 1'b1;
      nxt_st.err = ~hit;
      unique case (idx)
        INT_EN_IDX: rd = st_ff.int_en;
        EVT_STAT_IDX: rd = evt_q & EVT_VALID_MASK;
        TX_POL_IDX: rd = {12'h000, st_ff.txpol};
        RX_ERR_IDX: rd = 16'(cnt_q);
        PAGE_SEL_IDX: rd = {8'h00, st_ff.page};
        OEM_CTRL_IDX: rd = st_ff.oem;
        default: rd = 16'h0000;
      endcase
      if (!hit || pwrite)
      begin
        rd = 16'h0000;
      end
      nxt_st.rdata = {16'h0000, rd};
      // Snapshot what software sees so only those bits are cleared later
      nxt_st.snap_evt = evt_q & EVT_VALID_MASK;
      nxt_st.snap_cnt = cnt_q;
    end
    else if (access)
    begin
      nxt_st.err = 1'b0;
    end
    // Writes take effect at the access edge only; refused when out of map
    if (access && pwrite && !st_ff.err)
    begin
      unique case (idx)
        INT_EN_IDX:
        begin
          nxt_st.int_en = lane_merge(st_ff.int_en, pwdata, pstrb) & EVT_VALID_MASK;
        end
        TX_POL_IDX:
        begin
          wv = lane_merge({12'h000, st_ff.txpol}, pwdata, pstrb) & TX_POL_MASK;
          nxt_st.txpol = wv[3:0];
        end
        PAGE_SEL_IDX:
        begin
          wv = lane_merge({8'h00, st_ff.page}, pwdata, pstrb) & PAGE_SEL_MASK;
          nxt_st.page = wv[7:0];
        end
        OEM_CTRL_IDX:
        begin
          nxt_st.oem = lane_merge(st_ff.oem, pwdata, pstrb);
        end
        SW_RESET_IDX:
        begin
          nxt_st.swrst = pstrb[0] & pwdata[SW_RESET_BIT];
        end
        default:
        begin
          nxt_st.swrst = 1'b0;
        end
      endcase
    end
    // Software reset: OEM fields other than the retained ones return to zero
    if (st_ff.swrst)
    begin
      nxt_st.oem = st_ff.oem & OEM_RETAIN_MASK;
    end
    nxt_st.irq = |(evt_q & st_ff.int_en & EVT_VALID_MASK);
  end

  // State register; polarity, page and enables are untouched by software reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.rdata <= 32'h0000_0000;
      st_ff.ready <= 1'b0;
      st_ff.err <= 1'b0;
      st_ff.txpol <= TX_POL_RESET[3:0];
      st_ff.oem <= OEM_RESET;
      st_ff.page <= PAGE_SEL_RESET;
      st_ff.int_en <= INT_EN_RESET;
      st_ff.irq <= 1'b0;
      st_ff.snap_evt <= 16'h0000;
      st_ff.snap_cnt <= '0;
      st_ff.swrst <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops, except pslverr, which is err gated with ready
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err & st_ff.ready;
  assign tx_pair_invert = st_ff.txpol;
  assign aneg_restart = st_ff.oem[OEM_RESTART_BIT];
  assign gigabit_disable = st_ff.oem[OEM_GIG_DIS_BIT];
  assign low_power_link_select = st_ff.oem[OEM_LOW_POWER_BIT];
  assign page_sel = st_ff.page;
  assign soft_reset = st_ff.swrst;
  assign phy_int = st_ff.irq;

endmodule // pcsr_regs

// ---- sim/pcsr_regs_sva.sv ----
// Port-level checks of the copper status and control register bank
module pcsr_regs_sva
  import pcsr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Controls toward the copper core
  input wire logic [3:0] tx_pair_invert,
  input wire logic aneg_restart,
  input wire logic gigabit_disable,
  input wire logic low_power_link_select,
  input wire logic [7:0] page_sel,
  input wire logic soft_reset
);
  // Write that the bank accepts, low lane enabled
  logic acc_wr;
  // Read answer in the access cycle
  logic rd_ans;
  assign acc_wr = psel && penable && pready && pwrite && !pslverr && pstrb[0];
  assign rd_ans = pready && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Zero wait states: answer right after setup
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready && penable)
    else $error("no answer after setup");
  AST_RSVD_ZERO: assert property (
    rd_ans && paddr == 8'h4c |-> prdata[7] == 1'b0 && prdata[2] == 1'b0 && prdata[31:16] == 16'h0)
    else $error("reserved status bits set");
  AST_TXPOL_WR: assert property (
    acc_wr && paddr == 8'h50 |=> tx_pair_invert == $past(pwdata[3:0]))
    else $error("pair inversion not updated");
  AST_PAGE_WR: assert property (acc_wr && paddr == 8'h58 |=> page_sel == $past(pwdata[7:0]))
    else $error("page not updated");
  AST_PAGE_RD: assert property (
    rd_ans && !pslverr && paddr == 8'h58 |-> prdata == {24'h0, page_sel})
    else $error("page read wrong");
  AST_RESTART: assert property (
    acc_wr && paddr == 8'h64 && pstrb[1] && pwdata[10] |=> aneg_restart ##1 !aneg_restart)
    else $error("restart not a single pulse");
  AST_OEM_WR: assert property (
    acc_wr && paddr == 8'h64 |=> gigabit_disable == $past(pwdata[6])
      && low_power_link_select == $past(pwdata[2]))
    else $error("link controls not updated");
  AST_SOFT_KEEP: assert property (
    soft_reset |=> $stable(tx_pair_invert) && $stable(page_sel) && $stable(gigabit_disable))
    else $error("retained field lost on soft reset");
  // Unaligned or unmapped places are refused with zero data
  AST_REFUSE: assert property (
    pready && (paddr[1:0] != 2'b00 || paddr == 8'h40) |-> pslverr && prdata == 32'h0)
    else $error("bad address not refused");
  COV_EVT: cover property (rd_ans && paddr == 8'h4c && prdata != 32'h0);
  COV_SOFT: cover property (soft_reset);
  COV_ERR: cover property (pready && pslverr);
  COV_RESTART: cover property (aneg_restart);
endmodule // pcsr_regs_sva

// ---- sim/pcsr_core_model.sv ----
// Copper core stand-in: raises event pulses and moves status levels on command
module pcsr_core_model
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench command, one status bit position per cycle
  input wire logic go,
  input wire logic [3:0] sel,
  // Pulses by status bit position; faults stand behind bit 15
  output logic [15:0] pulse,
  output logic [3:0] fault,
  // Levels by status bit position; speed apart
  output logic [15:0] level,
  output logic [1:0] speed
);
  // Rotates through the four negotiation faults
  logic [1:0] fault_sel_ff;
  // Pulses last one cycle; a level toggles so each command is exactly one change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse <= 16'h0000;
      fault <= 4'h0;
      level <= 16'h0000;
      speed <= 2'h0;
      fault_sel_ff <= 2'h0;
    end
    else
    begin
      pulse <= 16'h0000;
      fault <= 4'h0;
      if (go)
      begin
        case (sel)
          4'hf:
          begin
            fault <= 4'h1 << fault_sel_ff;
            fault_sel_ff <= fault_sel_ff + 2'h1;
          end
          4'he: speed <= speed + 2'h1;
          4'hd, 4'ha, 4'h6, 4'h4, 4'h1: level[sel] <= !level[sel];
          // Pulses; positions 7 and 2 reach nothing
          default: pulse[sel] <= 1'b1;
        endcase
      end
    end
  end
endmodule // pcsr_core_model

// ---- sim/tb.sv ----
// Self-checking bench of the copper status and control register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // APB and control wires
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go;
  logic aneg_restart, gigabit_disable, low_power_link_select, phy_int;
  logic [7:0] paddr, page_sel;
  logic [31:0] pwdata, prdata, v, r;
  logic [3:0] pstrb, sel, tx_pair_invert, fault;
  logic [15:0] pulse, level;
  logic [1:0] speed;
  logic e;
  int n_errors, samples_checked, seed, n;
  // Registers readable on page 0
  logic [7:0] regs [6] = '{8'h48, 8'h4c, 8'h50, 8'h54, 8'h58, 8'h64};
  pcsr_core_model u_pcsr_core_model (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel),
    .pulse(pulse), .fault(fault), .level(level), .speed(speed));
  pcsr_regs #(.ADDR_W(8), .CNT_W(16)) u_pcsr_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ms_unresolved(fault[0]), .parallel_detect_fault(fault[1]),
    .no_highest_common_capability(fault[2]), .link_fail_after_aneg(fault[3]),
    .page_received(pulse[12]), .aneg_complete(pulse[11]), .symbol_err(pulse[9]),
    .false_carrier(pulse[8]), .downshift(pulse[5]), .fast_link_pulse_no_link(pulse[3]),
    .jabber(pulse[0]), .speed(speed), .full_duplex(level[13]), .link_up(level[10]),
    .mdix(level[6]), .energy_sleep(level[4]), .rx_pol_reversed(level[1]),
    .tx_pair_invert(tx_pair_invert), .aneg_restart(aneg_restart),
    .gigabit_disable(gigabit_disable), .low_power_link_select(low_power_link_select),
    .page_sel(page_sel), .soft_reset(), .phy_int(phy_int));
  // Status word expected after one event at position b
  function automatic logic [31:0] exp_evt(input int b);
    return (b == 7 || b == 2) ? 32'h0 : 32'h1 << b;
  endfunction
  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready with a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready mid-cycle, never in the time step of the edge that launches it
    @(negedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(negedge pclk);
      k++;
    end
    if (k >= 20)
    begin
      n_errors++;
      give_verdict;
    end
    // The answer stands unchanged up to the completing edge
    r = prdata;
    e = pslverr;
    // Completing edge: the request is held until here, then released
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare data and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // Ask the core model for one event
  task automatic fire(input logic [3:0] s);
    @(posedge pclk);
    go <= 1'b1;
    sel <= s;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // Counts, verdict, end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Free-running 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Hang guard near 95000 cycles, above the saturation run of some 66000
  initial
  begin
    #760000;
    n_errors++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, go} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h3;
    sel = 4'h0;
    seed = 70673;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0, 1'b0);
    $display("test reset values done");
    for (int b = 0; b < 16; b++)
      repeat ((b == 15) ? 4 : 1)
      begin
        fire(b[3:0]);
        rd(8'h4c, exp_evt(b), 1'b0);
        rd(8'h4c, 32'h0, 1'b0);
      end
    rd(8'h54, 32'h2, 1'b0);
    $display("test events done");
    n = ($random(seed) & 15) + 1;
    for (int i = 0; i < n; i++)
      fire(($random(seed) & 1) ? 4'h9 : 4'h8);
    rd(8'h54, 32'(n), 1'b0);
    @(posedge pclk);
    go <= 1'b1;
    sel <= 4'h9;
    repeat (65600) @(posedge pclk);
    go <= 1'b0;
    rd(8'h54, 32'hffff, 1'b0);
    rd(8'h54, 32'h0, 1'b0);
    apb(1'b0, 8'h4c, 32'h0);
    $display("test error count done");
    repeat (8)
    begin
      v = $random(seed) & 32'hf;
      wr_chk:
      begin
        apb(1'b1, 8'h50, v);
        @(negedge pclk);
        chk({28'h0, tx_pair_invert}, v);
      end
      rd(8'h50, v, 1'b0);
    end
    v = ($random(seed) & 32'hff) | 32'h1;
    apb(1'b1, 8'h58, v | 32'hff00);
    @(negedge pclk);
    chk({24'h0, page_sel}, v);
    rd(8'h58, v, 1'b0);
    rd(8'h54, 32'h0, 1'b1);
    apb(1'b1, 8'h58, 32'h0);
    apb(1'b1, 8'h64, 32'h0c44);
    @(negedge pclk);
    chk({29'h0, aneg_restart, gigabit_disable, low_power_link_select}, 32'h7);
    rd(8'h64, 32'h0844, 1'b0);
    $display("test controls done");
    apb(1'b1, 8'h48, 32'h10);
    fire(4'h4);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, phy_int}, 32'h1);
    rd(8'h4c, 32'h10, 1'b0);
    repeat (3) @(negedge pclk);
    chk({31'h0, phy_int}, 32'h0);
    fire(4'h5);
    repeat (4) @(negedge pclk);
    chk({31'h0, phy_int}, 32'h0);
    rd(8'h4c, 32'h20, 1'b0);
    $display("test interrupt done");
    apb(1'b1, 8'h50, 32'h5);
    fire(4'h9);
    fire(4'h0);
    apb(1'b1, 8'h58, 32'h3);
    apb(1'b1, 8'h7c, 32'h1);
    rd(8'h58, 32'h3, 1'b0);
    rd(8'h4c, 32'h0, 1'b1);
    apb(1'b1, 8'h58, 32'h0);
    rd(8'h4c, 32'h0, 1'b0);
    rd(8'h54, 32'h1, 1'b0);
    rd(8'h50, 32'h5, 1'b0);
    rd(8'h64, 32'h0044, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    rd(8'h4d, 32'h0, 1'b1);
    $display("test soft reset and refusals done");
    give_verdict;
  end
endmodule // tb
bind pcsr_regs pcsr_regs_sva #(.ADDR_W(ADDR_W)) u_pcsr_regs_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_pair_invert(tx_pair_invert), .aneg_restart(aneg_restart),
  .gigabit_disable(gigabit_disable), .low_power_link_select(low_power_link_select),
  .page_sel(page_sel), .soft_reset(soft_reset));
